// ### sfh_ctrl.sv
`timescale 1ns/1ps
`include "sfh_defs.svh"

module sfh_ctrl (
    // System.
    input  logic                 i_clk_sys,
    input  logic                 i_srst,
    // Wishbone slave.
    input  sfh_pkg::sfh_wb_req_s i_wb,
    output logic [31:0]          o_wb_dat,
    output logic                 o_wb_ack,
    // Flash pins.
    input  logic [3:0]           i_io_in,
    output sfh_pkg::sfh_pins_s   o_pins
);

    // =================================================================
    // Decoding functions.
    function automatic logic [7:0] op_of(input sfh_pkg::sfh_kind_e k,
                                         input logic p, input logic v);
        logic [7:0] r;
        r = 8'h00;
        if (p) begin
            r = v ? `SFH_OP_VWEN : `SFH_OP_WEN;
        end else begin
            case (k)
                sfh_pkg::k_wen:   r = `SFH_OP_WEN;
                sfh_pkg::k_wdis:  r = `SFH_OP_WDIS;
                sfh_pkg::k_vwen:  r = `SFH_OP_VWEN;
                sfh_pkg::k_wsr8:  r = `SFH_OP_WSR;
                sfh_pkg::k_wsr16: r = `SFH_OP_WSR;
                sfh_pkg::k_rsr1:  r = `SFH_OP_RSR1;
                sfh_pkg::k_rsr2:  r = `SFH_OP_RSR2;
                sfh_pkg::k_read:  r = `SFH_OP_READ;
                sfh_pkg::k_fast:  r = `SFH_OP_FAST;
                sfh_pkg::k_dout:  r = `SFH_OP_DOUT;
                sfh_pkg::k_qout:  r = `SFH_OP_QOUT;
                sfh_pkg::k_dio:   r = `SFH_OP_DIO;
                sfh_pkg::k_qio:   r = `SFH_OP_QIO;
                default:          r = 8'h00;
            endcase
        end
        return r;
    endfunction : op_of

    // Lane width code: 0 one line, 1 two lines, 2 four lines.
    function automatic logic [1:0] lw_of(input sfh_pkg::sfh_state_e s,
                                         input sfh_pkg::sfh_kind_e k);
        logic [1:0] r;
        r = 2'h0;
        if (s == sfh_pkg::s_adr || s == sfh_pkg::s_mod || s == sfh_pkg::s_rd) begin
            if (k == sfh_pkg::k_dio || (s == sfh_pkg::s_rd && k == sfh_pkg::k_dout)) begin
                r = 2'h1;
            end else if (k == sfh_pkg::k_qio
                         || (s == sfh_pkg::s_rd && k == sfh_pkg::k_qout)) begin
                r = 2'h2;
            end
        end
        return r;
    endfunction : lw_of

    function automatic logic [5:0] ncl_of(input sfh_pkg::sfh_state_e s,
                                          input sfh_pkg::sfh_kind_e k,
                                          input logic [1:0] n, input logic [1:0] w);
        logic [5:0] r;
        r = 6'h01;
        unique case (s)
            sfh_pkg::s_cmd: r = `SFH_NCL_BYTE;
            sfh_pkg::s_adr: r = `SFH_NCL_ADR >> w;
            sfh_pkg::s_mod: r = `SFH_NCL_BYTE >> w;
            sfh_pkg::s_dum: r = (k == sfh_pkg::k_qio) ? `SFH_DUM_QIO : `SFH_DUM_LONG;
            sfh_pkg::s_wr:  r = (k == sfh_pkg::k_wsr16) ? `SFH_NCL_WR16 : `SFH_NCL_BYTE;
            sfh_pkg::s_rd:  r = ({1'b0, n, 3'h0} + `SFH_NCL_BYTE) >> w;
            sfh_pkg::s_idle, sfh_pkg::s_gap: r = 6'h01;
        endcase
        return r;
    endfunction : ncl_of

    function automatic sfh_pkg::sfh_state_e nxt_of(input sfh_pkg::sfh_state_e s,
                                                   input sfh_pkg::sfh_kind_e k,
                                                   input logic p);
        sfh_pkg::sfh_state_e r;
        r = sfh_pkg::s_gap;
        unique case (s)
            sfh_pkg::s_cmd: begin
                if (p || k == sfh_pkg::k_wen || k == sfh_pkg::k_wdis
                    || k == sfh_pkg::k_vwen) begin
                    r = sfh_pkg::s_gap;
                end else if (k == sfh_pkg::k_wsr8 || k == sfh_pkg::k_wsr16) begin
                    r = sfh_pkg::s_wr;
                end else if (k == sfh_pkg::k_rsr1 || k == sfh_pkg::k_rsr2) begin
                    r = sfh_pkg::s_rd;
                end else begin
                    r = sfh_pkg::s_adr;
                end
            end
            sfh_pkg::s_adr: begin
                if (k == sfh_pkg::k_dio || k == sfh_pkg::k_qio) begin
                    r = sfh_pkg::s_mod;
                end else if (k == sfh_pkg::k_read) begin
                    r = sfh_pkg::s_rd;
                end else begin
                    r = sfh_pkg::s_dum;
                end
            end
            sfh_pkg::s_mod: r = (k == sfh_pkg::k_qio) ? sfh_pkg::s_dum : sfh_pkg::s_rd;
            sfh_pkg::s_dum: r = sfh_pkg::s_rd;
            sfh_pkg::s_idle, sfh_pkg::s_wr, sfh_pkg::s_rd, sfh_pkg::s_gap: r = sfh_pkg::s_gap;
        endcase
        return r;
    endfunction : nxt_of

    // =================================================================
    // State.
    sfh_pkg::sfh_kind_e  kind;
    sfh_pkg::sfh_state_e st;
    logic                vol;
    logic                pre;
    logic                sck;
    logic                err;
    logic                cont;
    logic                qe;
    logic [1:0]          nb;
    logic [23:0]         addr;
    logic [7:0]          modeb;
    logic [7:0]          div;
    logic [7:0]          cnt;
    logic [15:0]         wdat;
    logic [31:0]         rdat;
    logic [31:0]         sh;
    logic [5:0]          bits;
    logic [3:0]          io_m;
    logic [3:0]          io_s;
    logic [5:0]          wrc;
    logic [5:0]          dmc;

    // =================================================================
    // Bus decode.
    wire        wb_go    = i_wb.cyc & i_wb.stb & ~o_wb_ack;
    wire        wb_wr    = wb_go & i_wb.we;
    wire        idle     = (st == sfh_pkg::s_idle);
    wire        sel_ctrl = (i_wb.adr == `SFH_A_CTRL);
    wire        sel_addr = (i_wb.adr == `SFH_A_ADDR);
    wire        sel_wdat = (i_wb.adr == `SFH_A_WDAT);
    wire        sel_rdat = (i_wb.adr == `SFH_A_RDAT);
    wire        sel_stat = (i_wb.adr == `SFH_A_STAT);
    wire        sel_div  = (i_wb.adr == `SFH_A_DIV);
    wire        sel_cfg  = sel_ctrl | sel_addr | sel_wdat | sel_div;
    wire sfh_pkg::sfh_kind_e new_kind = sfh_pkg::sfh_kind_e'(i_wb.dat[3:0]);
    wire        new_wsr  = (new_kind == sfh_pkg::k_wsr8) | (new_kind == sfh_pkg::k_wsr16);
    wire        new_quad = (new_kind == sfh_pkg::k_qout) | (new_kind == sfh_pkg::k_qio);
    // Quad kinds are refused while the quad enable shadow is clear; continuous mode admits only its own kind.
    wire        refuse   = (new_quad & ~qe) | (cont & (new_kind != kind))
                         | (i_wb.dat[3:0] > `SFH_KIND_MAX);
    wire        start    = wb_wr & sel_ctrl & idle & ~refuse;
    wire        bad      = wb_wr & sel_cfg & (~idle | (sel_ctrl & refuse));
    wire        err_clr  = wb_wr & sel_stat & i_wb.dat[`SFH_STAT_ERR];
    wire [31:0] rd_mux   = sel_ctrl ? {22'h0, nb, 3'h0, vol, kind}
                         : sel_addr ? {modeb, addr}
                         : sel_wdat ? {16'h0, wdat}
                         : sel_rdat ? rdat
                         : sel_stat ? {28'h0, qe, cont, err, ~idle}
                         : sel_div  ? {24'h0, div} : 32'h0;

    // =================================================================
    // Serial engine decode.
    wire        tick    = (cnt == div);
    wire        fall    = tick & sck;
    wire        rise    = tick & ~sck;
    wire [1:0]  lw      = lw_of(st, kind);
    wire [5:0]  ncl     = ncl_of(st, kind, nb, lw);
    wire        last    = fall & (bits == ncl - 6'h01);
    wire        quad_k  = (kind == sfh_pkg::k_qout) | (kind == sfh_pkg::k_qio);
    wire        drive   = (st == sfh_pkg::s_cmd) | (st == sfh_pkg::s_adr)
                        | (st == sfh_pkg::s_mod) | (st == sfh_pkg::s_wr);
    wire        hold    = (st == sfh_pkg::s_dum) | (st == sfh_pkg::s_rd);
    wire        next_cs_n = idle | (st == sfh_pkg::s_gap);
    wire sfh_pkg::sfh_state_e next_st = nxt_of(st, kind, pre);
    wire [31:0] sh_shift = (lw == 2'h2) ? {sh[27:0], 4'h0}
                         : (lw == 2'h1) ? {sh[29:0], 2'h0} : {sh[30:0], 1'b0};
    // Status bytes go out first byte first, each MSB first.
    wire [31:0] sh_load  = (next_st == sfh_pkg::s_adr) ? {addr, 8'h00}
                         : (next_st == sfh_pkg::s_mod) ? {modeb, 24'h0}
                         : (next_st == sfh_pkg::s_wr)  ? {wdat[7:0], wdat[15:8], 16'h0}
                         : 32'h0;
    wire [31:0] rd_shift = (lw == 2'h2) ? {rdat[27:0], io_s}
                         : (lw == 2'h1) ? {rdat[29:0], io_s[1:0]} : {rdat[30:0], io_s[1]};
    // Lines 2 and 3 idle high so they never act as protect or hold by accident.
    wire [3:0]  next_oe_n = drive ? ((lw == 2'h0) ? `SFH_IDLE_OE : 4'h0)
                          : hold ? {quad_k, quad_k, 2'h3} : `SFH_IDLE_OE;
    wire [3:0]  next_out  = ~drive ? `SFH_IDLE_OUT
                          : (lw == 2'h2) ? sh[31:28]
                          : (lw == 2'h1) ? {2'h3, sh[31:30]} : {3'h6, sh[31]};

    // =================================================================
    // Bus slave: one wait-free answer, ack drops after one cycle.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= wb_go;
            o_wb_dat <= (wb_go & ~i_wb.we) ? rd_mux : o_wb_dat;
        end
    end

    // =================================================================
    // Configuration and status.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            kind  <= sfh_pkg::k_wen;
            vol   <= 1'b0;
            nb    <= 2'h0;
            addr  <= 24'h0;
            modeb <= 8'h00;
            wdat  <= 16'h0;
            div   <= `SFH_DIV_RST;
            err   <= 1'b0;
            cont  <= 1'b0;
            qe    <= 1'b0;
        end else begin
            if (start) begin
                kind <= new_kind;
                vol  <= i_wb.dat[4];
                nb   <= i_wb.dat[9:8];
            end
            if (wb_wr & idle & sel_addr) begin
                {modeb, addr} <= i_wb.dat;
            end
            if (wb_wr & idle & sel_wdat) begin
                wdat <= i_wb.dat[15:0];
            end
            if (wb_wr & idle & sel_div) begin
                div <= (i_wb.dat[7:0] < `SFH_DIV_MIN) ? `SFH_DIV_MIN : i_wb.dat[7:0];
            end
            err <= bad | (err & ~err_clr);
            if (st == sfh_pkg::s_mod && last) begin
                cont <= (modeb[5:4] == `SFH_CONT);
            end
            // The quad enable shadow follows what was written or last read back.
            if (st == sfh_pkg::s_wr && last) begin
                qe <= (kind == sfh_pkg::k_wsr16) & wdat[`SFH_QE_WR];
            end
            if (st == sfh_pkg::s_rd && last && kind == sfh_pkg::k_rsr2) begin
                qe <= rdat[`SFH_QE_RD];
            end
        end
    end

    // =================================================================
    // Serial engine. Data changes on the falling half, input is taken
    // just before the rising edge, so the divider must cover sync delay.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            st   <= sfh_pkg::s_idle;
            sck  <= 1'b0;
            bits <= 6'h0;
            cnt  <= 8'h00;
            sh   <= 32'h0;
            pre  <= 1'b0;
        end else if (start) begin
            st   <= cont ? sfh_pkg::s_adr : sfh_pkg::s_cmd;
            pre  <= new_wsr;
            sck  <= 1'b0;
            bits <= 6'h0;
            cnt  <= 8'h00;
            sh   <= cont ? {addr, 8'h00} : {op_of(new_kind, new_wsr, i_wb.dat[4]), 24'h0};
        end else if (!idle) begin
            cnt <= tick ? 8'h00 : cnt + 8'h01;
            if (st == sfh_pkg::s_gap) begin
                if (tick) begin
                    st  <= pre ? sfh_pkg::s_cmd : sfh_pkg::s_idle;
                    pre <= 1'b0;
                    sh  <= {op_of(kind, 1'b0, vol), 24'h0};
                end
            end else if (rise) begin
                sck <= 1'b1;
            end else if (fall) begin
                sck  <= 1'b0;
                bits <= last ? 6'h0 : bits + 6'h01;
                st   <= last ? next_st : st;
                sh   <= last ? sh_load : sh_shift;
            end
        end
    end

    // =================================================================
    // Input synchroniser, read capture and pin register.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            io_m <= 4'h0;
            io_s <= 4'h0;
            rdat <= 32'h0;
            o_pins <= '{1'b1, 1'b0, `SFH_IDLE_OUT, `SFH_IDLE_OE};
        end else begin
            io_m <= i_io_in;
            io_s <= io_m;
            if (start) begin
                rdat <= 32'h0;
            end else if (st == sfh_pkg::s_rd && rise) begin
                rdat <= rd_shift;
            end
            o_pins <= '{next_cs_n, sck, next_out, next_oe_n};
        end
    end

    // =================================================================
    // Checking helpers: clocks of the data write and dummy phases.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || start) begin
            wrc <= 6'h0;
            dmc <= 6'h0;
        end else begin
            wrc <= wrc + {5'h0, (st == sfh_pkg::s_wr) & rise};
            dmc <= dmc + {5'h0, (st == sfh_pkg::s_dum) & fall};
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    a_wsr_prefix: assert property (
        ($rose(st == sfh_pkg::s_cmd) && !pre
         && (kind == sfh_pkg::k_wsr8 || kind == sfh_pkg::k_wsr16))
        |-> $past(st) == sfh_pkg::s_gap && sh[31:24] == `SFH_OP_WSR)
        else $error("status write without enable prefix");
    a_vol_prefix: assert property (
        (st == sfh_pkg::s_cmd && bits == 6'h0 && pre)
        |-> sh[31:24] == (vol ? `SFH_OP_VWEN : `SFH_OP_WEN))
        else $error("wrong enable prefix code");
    a_wsr_bits: assert property (
        (st == sfh_pkg::s_wr && last)
        |=> st == sfh_pkg::s_gap && wrc == ((kind == sfh_pkg::k_wsr16) ? 6'h10 : 6'h08)
            ##1 o_pins.cs_n)
        else $error("chip select not raised after 8 or 16 bits");
    a_read_op: assert property (
        (st == sfh_pkg::s_cmd && bits == 6'h0 && kind == sfh_pkg::k_read)
        |-> sh[31:24] == `SFH_OP_READ)
        else $error("plain read code wrong");
    a_dummy_eight: assert property (
        ($fell(st == sfh_pkg::s_dum) && kind != sfh_pkg::k_qio) |-> dmc == 6'h08)
        else $error("fast read dummy count not eight");
    a_dual_release: assert property (
        (st == sfh_pkg::s_rd) |=> o_pins.io_oe_n[1:0] == 2'h3)
        else $error("data lines driven during read data");
    a_quad_qe: assert property (
        ($rose(!idle) && quad_k) |-> qe ##1 !o_pins.cs_n)
        else $error("quad read started without quad enable");
    a_dio_lanes: assert property (
        (st == sfh_pkg::s_adr && kind == sfh_pkg::k_dio)
        |=> o_pins.io_oe_n[1:0] == 2'h0)
        else $error("dual address not on two lines");
    a_mode_release: assert property (
        (st == sfh_pkg::s_mod && last) |=> ##1 o_pins.io_oe_n[0] && !o_pins.sck)
        else $error("line 0 not released after mode byte");
    a_cont_skip: assert property (
        ($past(idle) && st == sfh_pkg::s_adr) |-> cont)
        else $error("command byte skipped outside continuous mode");
    a_qio_dummy: assert property (
        ($fell(st == sfh_pkg::s_dum) && kind == sfh_pkg::k_qio) |-> dmc == 6'h04 && qe)
        else $error("quad I/O dummy count not four");

    c_wsr16: cover property (st == sfh_pkg::s_wr && last && kind == sfh_pkg::k_wsr16);
    c_qio:   cover property (st == sfh_pkg::s_rd && last && kind == sfh_pkg::k_qio);
    c_cont:  cover property (start && cont);
    c_vol:   cover property (st == sfh_pkg::s_gap && pre && vol);

endmodule : sfh_ctrl

// ### sfh_defs.svh
`ifndef SFH_DEFS_SVH
`define SFH_DEFS_SVH

// =====================================================================
// Flash instruction codes.
`define SFH_OP_WEN   8'h06
`define SFH_OP_WDIS  8'h04
`define SFH_OP_VWEN  8'h50
`define SFH_OP_WSR   8'h01
`define SFH_OP_RSR1  8'h05
`define SFH_OP_RSR2  8'h35
`define SFH_OP_READ  8'h03
`define SFH_OP_FAST  8'h0b
`define SFH_OP_DOUT  8'h3b
`define SFH_OP_QOUT  8'h6b
`define SFH_OP_DIO   8'hbb
`define SFH_OP_QIO   8'heb

// =====================================================================
// Register byte offsets.
`define SFH_A_CTRL   8'h00
`define SFH_A_ADDR   8'h04
`define SFH_A_WDAT   8'h08
`define SFH_A_RDAT   8'h0c
`define SFH_A_STAT   8'h10
`define SFH_A_DIV    8'h14

// =====================================================================
// Fields, reset values and clock counts.
`define SFH_KIND_MAX 4'hc
`define SFH_DIV_RST  8'h04
`define SFH_DIV_MIN  8'h03
`define SFH_CONT     2'h2
`define SFH_QE_WR    9
`define SFH_QE_RD    1
`define SFH_STAT_ERR 1
`define SFH_NCL_BYTE 6'h08
`define SFH_NCL_ADR  6'h18
`define SFH_NCL_WR16 6'h10
`define SFH_DUM_LONG 6'h08
`define SFH_DUM_QIO  6'h04
`define SFH_IDLE_OUT 4'hc
`define SFH_IDLE_OE  4'h2

`endif

// ### sfh_flash.sv
`timescale 1ns/1ps
// ==========
// Behavioural flash; the write cycle is shortened to TW system clocks.
module sfh_flash #(
    parameter int TW = 1500
) (
    // Link side.
    input  wire logic       i_clk,
    input  wire logic       i_cs_n,
    input  wire logic       i_sck,
    input  wire logic [3:0] i_io,
    output logic      [3:0] o_io,
    output logic      [3:0] o_drv
);
    logic [7:0]  cmd = 8'h00, cnt = 8'h00, oc = 8'h00, sr1 = 8'h00;
    logic [6:0]  sr2 = 7'h00;
    logic [31:0] am = 32'h0;
    logic        write_enable_latch = 1'b0, vwe = 1'b0, cont = 1'b0, ign = 1'b0, pcs = 1'b1;
    int          bt = 0;
    wire         dio = cmd == 8'hbb;
    wire         qio = cmd == 8'heb;
    wire         st  = cmd == 8'h05 || cmd == 8'h35;
    wire         qd  = cmd == 8'h6b || qio;
    wire [7:0]   la  = dio ? 8'h02 : qio ? 8'h04 : 8'h01;
    wire [7:0]   lo  = (cmd == 8'h3b || dio) ? 8'h02 : qd ? 8'h04 : 8'h01;
    wire [7:0]   ea  = 8'h08 + (dio || qio ? 8'h20 : 8'h18) / la;
    wire [7:0]   d0  = st ? 8'h08 : ea + (qio ? 8'h04 : (dio || cmd == 8'h03) ? 8'h00 : 8'h08);
    wire [23:0]  a   = (dio || qio) ? am[31:8] : am[23:0];
    wire [15:0]  bp  = 16'(oc - d0) * 16'(lo);
    wire [23:0]  ba  = a + 24'(bp[15:3]);
    wire [7:0]   byt = cmd == 8'h05 ? {sr1[7:2], write_enable_latch, bt != 0} : cmd == 8'h35 ? {1'b0, sr2}
                     : ba[7:0] ^ ba[15:8] ^ ba[23:16] ^ 8'h3c;
    wire [7:0]   sv  = byt << bp[2:0];
    wire [3:0]   nib = la == 8'h04 ? i_io : la == 8'h02 ? {2'b00, i_io[1:0]} : {3'b000, i_io[0]};
    wire         rdy = cmd inside {8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb} && !ign
                     && (sr2[1] || !qd);
    wire         fin = i_cs_n && !pcs;
    wire [7:0]   w1  = cnt == 8'h18 ? am[15:8] : am[7:0];
    assign o_io  = lo == 8'h04 ? sv[7:4] : lo == 8'h02 ? {2'b11, sv[7:6]} : {2'b11, sv[7], 1'b1};
    // Released lines float to the pull-up rather than holding stale data.
    assign o_drv = (!i_cs_n && oc >= d0 && (st || rdy))
                 ? (lo == 8'h04 ? 4'hf : lo == 8'h02 ? 4'h3 : 4'h2) : 4'h0;
    always @(posedge i_sck or negedge i_cs_n) begin
        if (!i_sck) begin
            cnt <= cont ? 8'h08 : 8'h00;
            ign <= bt != 0;
        end else begin
            cnt <= cnt + 8'h01;
            if (cnt < 8'h08) cmd <= {cmd[6:0], i_io[0]};
            else if (cnt < ea) am <= (am << la) | 32'(nib);
        end
    end
    always @(negedge i_sck or posedge i_cs_n) oc <= i_cs_n ? 8'h00 : cnt;
    always @(posedge i_clk) begin
        pcs <= i_cs_n;
        if (bt != 0) bt <= bt - 1;
        if (bt == 1) write_enable_latch <= 1'b0;
        if (fin && cnt == 8'h08 && cmd == 8'h06) write_enable_latch <= 1'b1;
        if (fin && cnt == 8'h08 && cmd == 8'h04) {write_enable_latch, vwe} <= 2'b00;
        if (fin && cnt == 8'h08 && cmd == 8'h50) vwe <= 1'b1;
        if (fin && (dio || qio) && cnt >= ea) cont <= am[5:4] == 2'b10;
        if (fin && cmd == 8'h01 && (cnt == 8'h10 || cnt == 8'h18) && (write_enable_latch || vwe)) begin
            sr1[7:2] <= w1[7:2];
            sr2 <= cnt == 8'h18 ? {am[6], am[5:2] | sr2[5:2], am[1], am[0] | (vwe & sr2[0])}
                 : {1'b0, sr2[5:2], 1'b0, vwe & sr2[0]};
            bt <= vwe ? 0 : TW;
            vwe <= 1'b0;
        end
    end
endmodule : sfh_flash

// ### sfh_pkg.sv
package sfh_pkg;

    // =================================================================
    // Transfer kinds, engine states and bundled signals.
    typedef enum logic [3:0] {
        k_wen  = 4'h0, k_wdis = 4'h1, k_vwen  = 4'h2, k_wsr8 = 4'h3,
        k_wsr16 = 4'h4, k_rsr1 = 4'h5, k_rsr2 = 4'h6, k_read = 4'h7,
        k_fast = 4'h8, k_dout = 4'h9, k_qout  = 4'ha, k_dio  = 4'hb,
        k_qio  = 4'hc
    } sfh_kind_e;

    typedef enum logic [2:0] {
        s_idle = 3'h0, s_cmd = 3'h1, s_adr = 3'h2, s_mod = 3'h3,
        s_dum  = 3'h4, s_wr  = 3'h5, s_rd  = 3'h6, s_gap = 3'h7
    } sfh_state_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } sfh_wb_req_s;

    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic [3:0] io_out;
        logic [3:0] io_oe_n;
    } sfh_pins_s;

endpackage : sfh_pkg

// ### tb_sfh_ctrl.sv
`timescale 1ns/1ps
`include "sfh_defs.svh"
`define CHK(x, y) begin n_tests++; if ((x) !== (y)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (x), (y)); end end
module tb_sfh_ctrl;
    logic                 i_clk_sys, i_srst;
    sfh_pkg::sfh_wb_req_s wb_r;
    logic [31:0]          wb_dat, q, ex;
    logic                 wb_ack;
    sfh_pkg::sfh_pins_s   pins;
    logic [3:0]           f_io, f_drv;
    wire  [3:0]           io = (~pins.io_oe_n & pins.io_out) | (pins.io_oe_n & f_drv & f_io)
                             | (pins.io_oe_n & ~f_drv);
    int                   errors, n_tests, nb;
    logic [23:0]          a;
    sfh_ctrl i_dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_wb(wb_r), .o_wb_dat(wb_dat),
                    .o_wb_ack(wb_ack), .i_io_in(io), .o_pins(pins));
    sfh_flash #(.TW(1500)) i_flash (.i_clk(i_clk_sys), .i_cs_n(pins.cs_n), .i_sck(pins.sck),
                                    .i_io(io), .o_io(f_io), .o_drv(f_drv));
    // ==========
    // Bus and frame helpers.
    task automatic print_verdict;
        if (errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
        int k;
        k = 0;
        wb_r <= '{1'b1, 1'b1, we, ad, 4'hf, d};
        do begin
            @(posedge i_clk_sys);
            k++;
        end while (wb_ack !== 1'b1 && k < 40);
        q = wb_dat;
        wb_r <= '0;
        @(posedge i_clk_sys);
        if (k >= 40) begin errors++; print_verdict(); end
    endtask : wb
    task automatic run(input logic [11:0] ctl, input logic [31:0] ad, input logic [15:0] wd);
        int k;
        wb(1'b1, `SFH_A_ADDR, ad);
        wb(1'b1, `SFH_A_WDAT, {16'h0, wd});
        wb(1'b1, `SFH_A_CTRL, {20'h0, ctl});
        for (k = 0; k < 400; k++) begin
            wb(1'b0, `SFH_A_STAT, 32'h0);
            if (q[0] === 1'b0) break;
        end
        if (k == 400) begin errors++; print_verdict(); end
        wb(1'b0, `SFH_A_RDAT, 32'h0);
    endtask : run
    task automatic sr(input logic [3:0] kd, input logic [7:0] e);
        run({8'h00, kd}, 32'h0, 16'h0);
        `CHK(q[7:0], e)
    endtask : sr
    // Software polls the flash itself, since the host does not time the write cycle.
    task automatic wt;
        int k;
        for (k = 0; k < 30 && q[0] !== 1'b0; k++) run(12'h005, 32'h0, 16'h0);
        if (q[0] !== 1'b0) begin errors++; print_verdict(); end
    endtask : wt
    function automatic logic [7:0] dv(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h3c;
    endfunction : dv
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        {errors, n_tests} = '0;
        wb_r = '0;
        i_srst = 1'b1;
        void'($urandom(6));
        repeat (10) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        @(posedge i_clk_sys);
        sr(4'h5, 8'h00);
        sr(4'h6, 8'h00);
        run(12'h000, 32'h0, 16'h0);
        sr(4'h5, 8'h02);
        run(12'h001, 32'h0, 16'h0);
        sr(4'h5, 8'h00);
        run(12'h004, 32'h0, 16'hffff);
        run(12'h007, 32'h100, 16'h0);
        `CHK(q[7:0], 8'hff)
        sr(4'h5, 8'hff);
        wt();
        sr(4'h5, 8'hfc);
        sr(4'h6, 8'h7f);
        run(12'h014, 32'h0, 16'h0000);
        sr(4'h5, 8'h00);
        sr(4'h6, 8'h3d);
        run(12'h003, 32'h0, 16'h0000);
        sr(4'h5, 8'h03);
        wt();
        sr(4'h6, 8'h3c);
        wb(1'b1, `SFH_A_CTRL, 32'h00a);
        wb(1'b0, `SFH_A_STAT, 32'h0);
        `CHK(q[1], 1'b1)
        wb(1'b1, `SFH_A_STAT, 32'h2);
        run(12'h014, 32'h0, 16'h0200);
        sr(4'h6, 8'h3e);
        for (int kd = 7; kd <= 12; kd++) begin
            repeat (2) begin
                a = (kd == 7) ? 24'hfffffe : 24'($urandom);
                nb = $urandom_range(3, 0);
                run({2'b00, 2'(nb), 4'h0, 4'(kd)}, {8'h00, a}, 16'h0);
                ex = 32'h0;
                for (int i = 0; i <= nb; i++) ex = {ex[23:0], dv(a + 24'(i))};
                `CHK(q, ex)
            end
        end
        run(12'h00b, {8'h20, 24'h123456}, 16'h0);
        `CHK(q[7:0], dv(24'h123456))
        wb(1'b0, `SFH_A_STAT, 32'h0);
        `CHK(q[2], 1'b1)
        run(12'h10b, {8'h00, 24'h00abcd}, 16'h0);
        `CHK(q[15:0], {dv(24'h00abcd), dv(24'h00abce)})
        run(12'h007, 32'h10, 16'h0);
        `CHK(q[7:0], dv(24'h000010))
        wb(1'b1, `SFH_A_DIV, 32'h1);
        wb(1'b0, `SFH_A_DIV, 32'h0);
        `CHK(q[7:0], 8'h03)
        wb(1'b0, 8'h20, 32'h0);
        `CHK(q, 32'h0)
        print_verdict();
    end
endmodule : tb_sfh_ctrl
